// File: tlic_pkg.sv
// package of constants and types for the two-level interrupt controller
package tlic_pkg;

    // ******************************************************
    // sources, in fixed tie-break order (index 0 wins)
    // ******************************************************
    localparam int NUM_SRC    = 11;
    localparam int SRC_EXT0   = 0;
    localparam int SRC_TMR0   = 1;
    localparam int SRC_EXT1   = 2;
    localparam int SRC_TMR1   = 3;
    localparam int SRC_SER    = 4;
    localparam int SRC_EXT2   = 5;
    localparam int SRC_EXT3   = 6;
    localparam int SRC_CID    = 7;
    localparam int SRC_DIV    = 8;
    localparam int SRC_CMP    = 9;
    localparam int SRC_WDT    = 10;

    typedef logic [NUM_SRC-1:0] tlic_src_vec_type;
    typedef logic [7:0]         tlic_vec_addr_type;

    localparam tlic_vec_addr_type VEC_TABLE [NUM_SRC] = '{
        8'h03, 8'h0b, 8'h13, 8'h1b, 8'h3b, 8'h43,
        8'h4b, 8'h53, 8'h5b, 8'h63, 8'h6b};

    // ******************************************************
    // enable register bit positions
    // ******************************************************
    localparam int IEN_EXT0   = 0;
    localparam int IEN_TMR0   = 1;
    localparam int IEN_EXT1   = 2;
    localparam int IEN_TMR1   = 3;
    localparam int IEN_SER    = 6;
    localparam int IEN_GLOBAL = 7;
    localparam int XEN_EXT2   = 0;
    localparam int XEN_EXT3   = 1;
    localparam int XEN_CID    = 2;
    localparam int XEN_DIV    = 3;
    localparam int XEN_CMP    = 4;
    localparam int XEN_WDT    = 5;

    // ******************************************************
    // register map (word aligned, byte addresses)
    // ******************************************************
    localparam logic [7:0] ADDR_IEN   = 8'h00;
    localparam logic [7:0] ADDR_XEN   = 8'h04;
    localparam logic [7:0] ADDR_PRIO  = 8'h08;
    localparam logic [7:0] ADDR_CTRL  = 8'h0c;
    localparam logic [7:0] ADDR_FLAGS = 8'h10;
    localparam logic [7:0] ADDR_STAT  = 8'h14;

    localparam int CTRL_IT0  = 0;
    localparam int CTRL_IT1  = 1;
    localparam int CTRL_IDLE_SKIP_SERVICE_BIT = 2;

    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [1:0]  RESP_OKAY   = 2'b00;
    localparam logic [1:0]  RESP_SLVERR = 2'b10;

    // core-side handshake status for one machine cycle
    typedef struct packed {
        logic mcycleStrobe;   // one clock per machine cycle: poll point
        logic lastCycle;      // this is the instruction's last machine cycle
        logic prioWrite;      // instruction writes enable/priority registers
        logic serviceExit;    // service-exit instruction executed
        logic idle;           // core is idle
    } tlic_core_type;

    // grant to the core
    typedef struct packed {
        logic              callValid; // one-cycle long vector call request
        tlic_vec_addr_type callAddr;
        logic              wake;      // leave idle
        logic              skipIsr;   // wake without running service routine
    } tlic_grant_type;

endpackage

// File: tlic_controller.sv
// two-level interrupt controller with AXI4-Lite registers
// Behaviour
// - ext0/ext1 edge or level trigger, chosen by their trigger-type bits.
// - edge mode: high sample then low sample next machine cycle sets flag.
// - edge-mode external flag cleared by hardware on vectoring.
// - level mode: flag follows pin, not cleared on service entry.
// - ext2 and ext3 are edge triggered only.
// - timer overflows set flags; hardware clears them on service.
// - watchdog flag set on every time-out regardless of its enable; cleared only by software.
// - one serial flag for receive and transmit; cleared on service.
// - divider overflow flag set on every overflow regardless of its enable; cleared on service.
// - comparator flag set on rising comparator result.
// - caller-ID flag is OR of event flags; never cleared on service.
// - global gate off blocks all; on, each source uses its own bit.
// - enable bit placement in enable and extended enable registers.
// - two priority levels; low never interrupts high.
// - fixed tie-break order and vector table.
// - sample, poll and resolve each machine cycle; issue vector call.
// - call only if no equal/higher in service, last cycle, no reg write; in idle the last-cycle test is skipped.
// - requests are not remembered between polling cycles.
// - only service-exit instruction ends in-service state.
// - eleven sources, each with priority, flag, vector, enable.
// - runs in idle; enabled request wakes core, skip bit chooses service.
`timescale 1ns/1ps
module tlic_controller
    import tlic_pkg::*;
(
    input  wire logic             mclk,          // 25 MHz system clock
    input  wire logic             nrst,          // sync reset, active low
    input  wire logic             clkEn,         // freezes all state when low
    input  wire logic             extIrq0Pin,    // external interrupt 0 pin
    input  wire logic             extIrq1Pin,    // external interrupt 1 pin
    input  wire logic             extIrq2Pin,    // external interrupt 2 pin
    input  wire logic             extIrq3Pin,    // external interrupt 3 pin
    input  wire logic             tmr0Ovf,       // timer 0 overflow pulse
    input  wire logic             tmr1Ovf,       // timer 1 overflow pulse
    input  wire logic             serialEvt,     // serial rx/tx done pulse
    input  wire logic             dividerOvf,    // divider overflow pulse
    input  wire logic             comparatorResult, // live comparator level
    input  wire logic [7:0]       callerIdEvents,   // caller-ID event flags
    input  wire logic             watchdogTimeout,  // watchdog time-out pulse
    input  wire tlic_core_type    core,          // core status
    output tlic_grant_type        grant,         // call request to core
    output logic [1:0]            inService,     // in-service: [1] high
    input  wire logic [7:0]       s_axi_awaddr,  // write address
    input  wire logic             s_axi_awvalid, // write address valid
    output logic                  s_axi_awready, // write address ready
    input  wire logic [31:0]      s_axi_wdata,   // write data
    input  wire logic [3:0]       s_axi_wstrb,   // write strobes
    input  wire logic             s_axi_wvalid,  // write data valid
    output logic                  s_axi_wready,  // write data ready
    output logic [1:0]            s_axi_bresp,   // write response
    output logic                  s_axi_bvalid,  // write response valid
    input  wire logic             s_axi_bready,  // write response ready
    input  wire logic [7:0]       s_axi_araddr,  // read address
    input  wire logic             s_axi_arvalid, // read address valid
    output logic                  s_axi_arready, // read address ready
    output logic [31:0]           s_axi_rdata,   // read data
    output logic [1:0]            s_axi_rresp,   // read response
    output logic                  s_axi_rvalid,  // read data valid
    input  wire logic             s_axi_rready   // read data ready
);

    // ******************************************************
    // registers
    // ******************************************************
    logic [7:0]       ienQ;
    logic [7:0]       xenQ;
    tlic_src_vec_type prioQ;
    logic [2:0]       ctrlQ;
    tlic_src_vec_type flagQ;
    logic             ext0PrevQ, ext1PrevQ, ext2PrevQ, ext3PrevQ;
    logic             cmpPrevQ;
    logic [1:0]       inServiceQ;
    tlic_grant_type   grantQ;

    // ******************************************************
    // AXI4-Lite slave
    // ******************************************************
    logic [7:0]  awAddrQ;
    logic        awHeldQ;
    logic [31:0] wDataQ;
    logic [3:0]  wStrbQ;
    logic        wHeldQ;
    logic        bValidQ;
    logic [1:0]  bRespQ;
    logic        rValidQ;
    logic [31:0] rDataQ;
    logic [1:0]  rRespQ;
    logic        wrFire;
    logic        wrMapped;
    tlic_src_vec_type swClear;

    assign s_axi_awready = !awHeldQ && !bValidQ;
    assign s_axi_wready  = !wHeldQ && !bValidQ;
    assign s_axi_arready = !rValidQ;
    assign s_axi_bvalid  = bValidQ;
    assign s_axi_bresp   = bRespQ;
    assign s_axi_rvalid  = rValidQ;
    assign s_axi_rdata   = rDataQ;
    assign s_axi_rresp   = rRespQ;
    assign wrFire   = clkEn && awHeldQ && wHeldQ && !bValidQ;
    assign wrMapped = awAddrQ == ADDR_IEN || awAddrQ == ADDR_XEN ||
                      awAddrQ == ADDR_PRIO || awAddrQ == ADDR_CTRL ||
                      awAddrQ == ADDR_FLAGS;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            awHeldQ <= 1'b0;
            awAddrQ <= RST_BYTE;
        end else if (clkEn) begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeldQ <= 1'b1;
                awAddrQ <= s_axi_awaddr;
            end else if (wrFire) begin
                awHeldQ <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            wHeldQ <= 1'b0;
            wDataQ <= RST_WORD;
            wStrbQ <= 4'h0;
        end else if (clkEn) begin
            if (s_axi_wvalid && s_axi_wready) begin
                wHeldQ <= 1'b1;
                wDataQ <= s_axi_wdata;
                wStrbQ <= s_axi_wstrb;
            end else if (wrFire) begin
                wHeldQ <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            bValidQ <= 1'b0;
            bRespQ  <= RESP_OKAY;
        end else if (clkEn) begin
            if (wrFire) begin
                bValidQ <= 1'b1;
                bRespQ  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bValidQ <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            rValidQ <= 1'b0;
            rDataQ  <= RST_WORD;
            rRespQ  <= RESP_OKAY;
        end else if (clkEn) begin
            if (s_axi_arvalid && s_axi_arready) begin
                rValidQ <= 1'b1;
                rRespQ  <= RESP_OKAY;
                case (s_axi_araddr)
                    ADDR_IEN:   rDataQ <= {24'h0, ienQ};
                    ADDR_XEN:   rDataQ <= {24'h0, xenQ};
                    ADDR_PRIO:  rDataQ <= {21'h0, prioQ};
                    ADDR_CTRL:  rDataQ <= {29'h0, ctrlQ};
                    ADDR_FLAGS: rDataQ <= {21'h0, flagQ};
                    ADDR_STAT:  rDataQ <= {30'h0, inServiceQ};
                    default: begin
                        rDataQ <= RST_WORD;
                        rRespQ <= RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rready) begin
                rValidQ <= 1'b0;
            end
        end
    end

    // config writes use strobe 0; priority bits 10:8 use strobe 1
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            ienQ  <= RST_BYTE;
            xenQ  <= RST_BYTE;
            prioQ <= '0;
        end else if (wrFire) begin
            if (awAddrQ == ADDR_IEN && wStrbQ[0])
                ienQ <= wDataQ[7:0];
            if (awAddrQ == ADDR_XEN && wStrbQ[0])
                xenQ <= wDataQ[7:0];
            if (awAddrQ == ADDR_PRIO) begin
                if (wStrbQ[0])
                    prioQ[7:0] <= wDataQ[7:0];
                if (wStrbQ[1])
                    prioQ[NUM_SRC-1:8] <= wDataQ[NUM_SRC-1:8];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            ctrlQ <= '0;
        end else if (wrFire && awAddrQ == ADDR_CTRL && wStrbQ[0]) begin
            ctrlQ <= wDataQ[2:0];
        end
    end

    // write one to clear a flag
    always_comb begin
        swClear = '0;
        if (wrFire && awAddrQ == ADDR_FLAGS) begin
            swClear[7:0] = wStrbQ[0] ? wDataQ[7:0] : 8'h00;
            swClear[NUM_SRC-1:8] =
                wStrbQ[1] ? wDataQ[NUM_SRC-1:8] : 3'b000;
        end
    end

    // ******************************************************
    // per-machine-cycle sampling and flag sources
    // ******************************************************
    logic             mc;
    logic             fall0, fall1, fall2, fall3, cmpRise;
    tlic_src_vec_type setEvt;
    tlic_src_vec_type hwClear;
    logic [3:0]       srcIdx;
    logic             winValid;
    logic             callOk;
    logic             callGo;

    assign mc = clkEn && core.mcycleStrobe;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            ext0PrevQ <= 1'b1;
            ext1PrevQ <= 1'b1;
            ext2PrevQ <= 1'b1;
            ext3PrevQ <= 1'b1;
        end else if (mc) begin
            ext0PrevQ <= extIrq0Pin;
            ext1PrevQ <= extIrq1Pin;
            ext2PrevQ <= extIrq2Pin;
            ext3PrevQ <= extIrq3Pin;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            cmpPrevQ <= 1'b0;
        end else if (clkEn) begin
            cmpPrevQ <= comparatorResult;
        end
    end

    // sources hold each level a machine cycle
    assign fall0   = mc && ext0PrevQ && !extIrq0Pin;
    assign fall1   = mc && ext1PrevQ && !extIrq1Pin;
    assign fall2   = mc && ext2PrevQ && !extIrq2Pin;
    assign fall3   = mc && ext3PrevQ && !extIrq3Pin;
    assign cmpRise = comparatorResult && !cmpPrevQ;

    always_comb begin
        setEvt = '0;
        setEvt[SRC_EXT0] = fall0;
        setEvt[SRC_TMR0] = tmr0Ovf;
        setEvt[SRC_EXT1] = fall1;
        setEvt[SRC_TMR1] = tmr1Ovf;
        setEvt[SRC_SER]  = serialEvt;
        setEvt[SRC_EXT2] = fall2;
        setEvt[SRC_EXT3] = fall3;
        setEvt[SRC_DIV]  = dividerOvf;
        setEvt[SRC_CMP]  = cmpRise;
        setEvt[SRC_WDT]  = watchdogTimeout;
    end

    // clear on vectoring; never cid or watchdog
    always_comb begin
        hwClear = '0;
        if (callGo) begin
            hwClear[srcIdx] = 1'b1;
        end
        hwClear[SRC_CID] = 1'b0;
        hwClear[SRC_WDT] = 1'b0;
    end

    // set beats clear; level-mode ext flags track the pin
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            flagQ <= '0;
        end else if (clkEn) begin
            flagQ <= setEvt | (flagQ & ~hwClear & ~swClear);
            if (ctrlQ[CTRL_IT0] == 1'b0)
                flagQ[SRC_EXT0] <= !extIrq0Pin;
            if (ctrlQ[CTRL_IT1] == 1'b0)
                flagQ[SRC_EXT1] <= !extIrq1Pin;
            flagQ[SRC_CID] <= |callerIdEvents;
        end
    end

    // ******************************************************
    // enables, priority resolution and call generation
    // ******************************************************
    tlic_src_vec_type enVec;
    tlic_src_vec_type req;
    tlic_src_vec_type reqHi, reqLo;
    logic             winHi;

    always_comb begin
        enVec = '0;
        enVec[SRC_EXT0] = ienQ[IEN_EXT0];
        enVec[SRC_TMR0] = ienQ[IEN_TMR0];
        enVec[SRC_EXT1] = ienQ[IEN_EXT1];
        enVec[SRC_TMR1] = ienQ[IEN_TMR1];
        enVec[SRC_SER]  = ienQ[IEN_SER];
        enVec[SRC_EXT2] = xenQ[XEN_EXT2];
        enVec[SRC_EXT3] = xenQ[XEN_EXT3];
        enVec[SRC_CID]  = xenQ[XEN_CID];
        enVec[SRC_DIV]  = xenQ[XEN_DIV];
        enVec[SRC_CMP]  = xenQ[XEN_CMP];
        enVec[SRC_WDT]  = xenQ[XEN_WDT];
    end

    // live flags only
    assign req   = ienQ[IEN_GLOBAL] ? (flagQ & enVec) : '0;
    assign reqHi = req & prioQ;
    assign reqLo = req & ~prioQ;

    // lowest index wins
    always_comb begin
        srcIdx   = '0;
        winValid = 1'b0;
        winHi    = 1'b0;
        if (|reqHi && !inServiceQ[1]) begin
            winValid = 1'b1;
            winHi    = 1'b1;
            for (int i = NUM_SRC - 1; i >= 0; i--) begin
                if (reqHi[i])
                    srcIdx = 4'(i);
            end
        end else if (|reqLo && inServiceQ == 2'b00) begin
            winValid = 1'b1;
            for (int i = NUM_SRC - 1; i >= 0; i--) begin
                if (reqLo[i])
                    srcIdx = 4'(i);
            end
        end
    end

    // idle wake skips the boundary test
    assign callOk = mc && !core.prioWrite &&
                    (core.lastCycle || core.idle);
    assign callGo = winValid && callOk && !grantQ.callValid &&
                    !(core.idle && ctrlQ[CTRL_IDLE_SKIP_SERVICE_BIT]);

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            grantQ <= '0;
        end else if (clkEn) begin
            grantQ.callValid <= 1'b0;
            grantQ.wake      <= 1'b0;
            grantQ.skipIsr   <= 1'b0;
            if (core.idle && |req) begin
                grantQ.wake    <= 1'b1;
                grantQ.skipIsr <= ctrlQ[CTRL_IDLE_SKIP_SERVICE_BIT];
            end
            if (callGo) begin
                grantQ.callValid <= 1'b1;
                grantQ.callAddr  <= VEC_TABLE[srcIdx];
            end
        end
    end

    // in-service per level
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            inServiceQ <= 2'b00;
        end else if (clkEn) begin
            if (core.serviceExit) begin
                if (inServiceQ[1])
                    inServiceQ[1] <= 1'b0;
                else
                    inServiceQ[0] <= 1'b0;
            end
            if (callGo) begin
                inServiceQ[winHi] <= 1'b1;
            end
        end
    end

    assign grant     = grantQ;
    assign inService = inServiceQ;

endmodule

// File: tlic_checker.sv
// assertion checker for the two-level interrupt controller
`timescale 1ns/1ps
module tlic_checker
    import tlic_pkg::*;
(
    input wire logic           mclk,          // clock
    input wire logic           nrst,          // reset
    input wire logic           clkEn,         // clock enable
    input wire tlic_core_type  core,          // core status
    input wire tlic_grant_type grant,         // call request
    input wire logic [1:0]     inService,     // levels in service
    input wire logic           s_axi_arvalid, // ar valid
    input wire logic           s_axi_arready, // ar ready
    input wire logic           s_axi_rvalid,  // r valid
    input wire logic           s_axi_rready,  // r ready
    input wire logic [31:0]    s_axi_rdata    // r data
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    // ****************************************
    // grant, in-service levels and read channel
    // ****************************************
    sequence s_pulse;
        grant.callValid ##1 !grant.callValid;
    endsequence
    sequence s_read;
        s_axi_arvalid && s_axi_arready && clkEn ##1 s_axi_rvalid;
    endsequence
    property p_pulse; grant.callValid |-> s_pulse; endproperty
    a_pulse: assert property (p_pulse)
        else $error("call not a single pulse");
    property p_cond;
        grant.callValid |-> $past(clkEn && core.mcycleStrobe
            && (core.lastCycle || core.idle) && !core.prioWrite);
    endproperty
    a_cond: assert property (p_cond)
        else $error("call outside a legal poll");
    property p_vec;
        grant.callValid |-> grant.callAddr inside {VEC_TABLE};
    endproperty
    a_vec: assert property (p_vec)
        else $error("call to unknown vector");
    property p_ins; grant.callValid |-> inService != 2'b00; endproperty
    a_ins: assert property (p_ins)
        else $error("call without in-service level");
    property p_high;
        grant.callValid |-> !$past(inService[1]) || $past(core.serviceExit);
    endproperty
    a_high: assert property (p_high)
        else $error("call while high level in service");
    property p_exit;
        clkEn && core.serviceExit && inService[1]
            |=> !inService[1] || grant.callValid;
    endproperty
    a_exit: assert property (p_exit)
        else $error("exit left high level set");
    property p_keep; inService[1] && !core.serviceExit |=> inService[1];
    endproperty
    a_keep: assert property (p_keep)
        else $error("high level ended without exit");
    property p_rresp;
        s_axi_arvalid && s_axi_arready && clkEn |-> s_read;
    endproperty
    a_rresp: assert property (p_rresp)
        else $error("read answer late");
    property p_rhold;
        s_axi_rvalid && !s_axi_rready
            |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rhold: assert property (p_rhold)
        else $error("read data dropped");
endmodule

bind tlic_controller tlic_checker u_chk (
    .mclk(mclk), .nrst(nrst), .clkEn(clkEn), .core(core), .grant(grant),
    .inService(inService), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));

// File: tlic_core_model.sv
// core model: machine cycles, poll blocking and service exits
`timescale 1ns/1ps
module tlic_core_model
    import tlic_pkg::*;
(
    input  wire logic       mclk,    // clock
    input  wire logic       nrst,    // reset
    input  wire logic [1:0] hold,    // [0] not last cycle, [1] reg write
    input  wire logic       exitReq, // service-exit pulse
    output tlic_core_type   core     // status to controller
);
    // ****************************************
    // machine cycle of four clocks
    // ****************************************
    logic [1:0] phase_q;
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            phase_q <= 2'h0;
        end else begin
            phase_q <= phase_q + 2'h1;
        end
    end
    assign core = '{mcycleStrobe: (phase_q == 2'h3),
                    lastCycle: !hold[0],
                    prioWrite: hold[1],
                    serviceExit: exitReq,
                    idle: 1'b0};
endmodule

// File: tb_two_level_interrupt_controller.sv
// self-checking testbench of the two-level interrupt controller
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
    fail_count++; \
    $display("unexpected at %0t got %h expected %h", $time, a, e); end end
module tb_two_level_interrupt_controller
    import tlic_pkg::*;
;
    localparam int LIM = 400;
    logic           mclk = 1'b0;
    logic           nrst = 1'b0;
    logic [3:0]     extPin = 4'hf;
    logic [4:0]     evt = 5'h0;
    logic           cmpRes = 1'b0;
    logic [7:0]     cidEvt = 8'h00;
    logic [1:0]     hold = 2'h0;
    logic           exitReq = 1'b0;
    logic [7:0]     s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0]    s_axi_wdata = 32'h0;
    logic           s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1;
    logic           s_axi_arvalid = 0, s_axi_rready = 1;
    tlic_core_type  core;
    tlic_grant_type grant;
    logic [1:0]     inService, s_axi_bresp, s_axi_rresp;
    logic           s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic           s_axi_arready, s_axi_rvalid;
    logic [31:0]    s_axi_rdata, exp32;
    logic [7:0]     callQ[$];
    logic [31:0]    rdQ[$];
    logic [7:0]     vt[4] = '{8'h0b, 8'h1b, 8'h3b, 8'h5b};
    logic [7:0]     ve[4] = '{8'h03, 8'h13, 8'h43, 8'h4b};
    int             fail_count = 0, samples_checked = 0, seed = 46;

    always #20 mclk = ~mclk;
    tlic_controller DUT (
        .mclk(mclk), .nrst(nrst), .clkEn(1'b1),
        .extIrq0Pin(extPin[0]), .extIrq1Pin(extPin[1]),
        .extIrq2Pin(extPin[2]), .extIrq3Pin(extPin[3]),
        .tmr0Ovf(evt[4]), .tmr1Ovf(evt[3]), .serialEvt(evt[2]),
        .dividerOvf(evt[1]), .watchdogTimeout(evt[0]),
        .comparatorResult(cmpRes), .callerIdEvents(cidEvt),
        .core(core), .grant(grant), .inService(inService),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready));
    tlic_core_model u_core (.mclk(mclk), .nrst(nrst), .hold(hold),
        .exitReq(exitReq), .core(core));

    // ****************************************
    // monitor and bus tasks
    // ****************************************
    always @(posedge mclk) begin
        if (grant.callValid === 1'b1) begin
            exp32 = callQ.pop_front();
            `CHK(grant.callAddr, exp32)
        end
        if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
            exp32 = (rdQ.size() > 0) ? rdQ.pop_front() : 32'hdeadbeef;
            `CHK(s_axi_rdata, exp32)
        end
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic lim(input int n);
        if (n >= LIM) begin
            fail_count++;
            end_sim();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        int n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && ++n < LIM);
        lim(n);
        `CHK(s_axi_bresp, er)
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er);
        int n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        rdQ.push_back(e);
        do begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && ++n < LIM);
        lim(n);
        `CHK(s_axi_rresp, er)
    endtask
    task automatic svc(input logic [7:0] v);
        int n = 0;
        callQ.push_back(v);
        do @(posedge mclk); while (grant.callValid !== 1'b1 && ++n < LIM);
        lim(n);
    endtask
    task automatic ex();
        exitReq <= 1'b1;
        @(posedge mclk);
        exitReq <= 1'b0;
    endtask
    task automatic pulse(input logic [4:0] m);
        evt <= m;
        @(posedge mclk);
        evt <= 5'h0;
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (4) @(posedge mclk);
        nrst <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            rd(8'(i * 4), RST_WORD, (i < 6) ? RESP_OKAY : RESP_SLVERR);
        end
        wr(ADDR_STAT, 32'h3, RESP_SLVERR);
        wr(8'h40, 32'h1, RESP_SLVERR);
        wr(ADDR_IEN, 32'hcf, RESP_OKAY);
        wr(ADDR_XEN, 32'h3f, RESP_OKAY);
        wr(ADDR_CTRL, 32'h3, RESP_OKAY);
        pulse(5'h1f);
        foreach (vt[i]) begin
            svc(vt[i]);
            ex();
        end
        svc(8'h6b);
        rd(ADDR_FLAGS, 32'h400, RESP_OKAY);
        wr(ADDR_FLAGS, 32'h400, RESP_OKAY);
        ex();
        cmpRes <= 1'b1;
        cidEvt <= 8'($random(seed)) | 8'h01;
        svc(8'h53);
        rd(ADDR_FLAGS, 32'h280, RESP_OKAY);
        cidEvt <= 8'h00;
        ex();
        svc(8'h63);
        wr(ADDR_FLAGS, 32'h200, RESP_OKAY);
        ex();
        foreach (ve[k]) begin
            extPin[k] <= 1'b0;
            svc(ve[k]);
            ex();
            repeat (16) @(posedge mclk);
            extPin[k] <= 1'b1;
            repeat (8) @(posedge mclk);
        end
        wr(ADDR_CTRL, 32'h1, RESP_OKAY);
        extPin[1] <= 1'b0;
        svc(8'h13);
        ex();
        svc(8'h13);
        extPin[1] <= 1'b1;
        ex();
        repeat (16) @(posedge mclk);
        wr(ADDR_PRIO, 32'h8, RESP_OKAY);
        pulse(5'h10);
        svc(8'h0b);
        pulse(5'h08);
        svc(8'h1b);
        rd(ADDR_STAT, 32'h3, RESP_OKAY);
        pulse(5'h04);
        repeat (16) @(posedge mclk);
        ex();
        rd(ADDR_STAT, 32'h1, RESP_OKAY);
        ex();
        svc(8'h3b);
        ex();
        wr(ADDR_IEN, 32'h4f, RESP_OKAY);
        pulse(5'h10);
        repeat (16) @(posedge mclk);
        hold <= 2'b01;
        wr(ADDR_IEN, 32'hcf, RESP_OKAY);
        repeat (16) @(posedge mclk);
        hold <= 2'b10;
        repeat (16) @(posedge mclk);
        hold <= 2'b00;
        svc(8'h0b);
        ex();
        repeat (16) @(posedge mclk);
        `CHK(callQ.size(), 0)
        end_sim();
    end
endmodule
